// ===== src/ccp_compare_cfg.svh
// register offsets, field positions, reset values and select codes of the compare pair
`ifndef CCP_COMPARE_CFG_SVH
`define CCP_COMPARE_CFG_SVH

// register bus geometry
`define CCP_ADDR_W        4
`define CCP_DATA_W        8

// register offsets (byte registers, one per address)
`define OFS_U1_VALUE_LOW  4'h0
`define OFS_U1_VALUE_HIGH 4'h1
`define OFS_U1_CONTROL    4'h2
`define OFS_U2_VALUE_LOW  4'h3
`define OFS_U2_VALUE_HIGH 4'h4
`define OFS_U2_CONTROL    4'h5
`define OFS_TIMEBASE_SEL  4'h6
`define OFS_MATCH_STATUS  4'h7
`define OFS_MATCH_MASK    4'h8
`define OFS_PIN_STATE     4'h9

// control register layout
`define CTRL_MODE_MSB     3
`define CTRL_MODE_LSB     0
`define CTRL_DUTY_MSB     5
`define CTRL_DUTY_LSB     4
`define CTRL_WRITE_MASK   8'h3F
`define CTRL_RESET        8'h00

// status, mask and pin-state layout: one bit per unit
`define BIT_UNIT1         0
`define BIT_UNIT2         1
`define FLAGS_RESET       2'h0

// time base select field and its codes
`define TBSEL_MSB         1
`define TBSEL_LSB         0
`define TBSEL_RESET       2'h0
`define TBSEL_ALL_A       2'h0
`define TBSEL_SPLIT       2'h1

// reset values of datapath bytes
`define BYTE_RESET        8'h00
`define WORD_RESET        16'h0000
`define READ_ZERO         8'h00

`endif

// ===== src/ccp_compare_pkg.sv
// types shared by the compare pair: mode codes and state records
package ccp_compare_pkg;

	// mode select codes that the compare logic acts upon
	typedef enum logic [3:0] {
		MODE_OFF      = 4'b0000,
		MODE_TOGGLE   = 4'b0010,
		MODE_SET_HIGH = 4'b1000,
		MODE_SET_LOW  = 4'b1001,
		MODE_SOFT     = 4'b1010,
		MODE_TRIGGER  = 4'b1011
	} mode_e;

	// state of one compare channel
	typedef struct packed {
		logic pinLevel;
		logic equalPrev;
	} chan_s;

	// state of the register file
	typedef struct packed {
		logic [1:0][7:0] valueLow;
		logic [1:0][7:0] valueHigh;
		logic [1:0][7:0] control;
		logic [1:0]      timebaseSel;
		logic [1:0]      matchStatus;
		logic [1:0]      matchMask;
		logic [7:0]      readData;
	} regs_s;

endpackage : ccp_compare_pkg

// ===== src/ccp_compare_channel.sv
// one compare channel: equality detect, pin latch and trigger generation
`timescale 1ns/1ps
module ccp_compare_channel (
	input  wire logic        clk,          // system clock
	input  wire logic        resetn,       // synchronous reset, active low
	input  wire logic [3:0]  mode,         // current mode select field
	input  wire logic        modeWrite,    // control register written this cycle
	input  wire logic [3:0]  modeNew,      // mode value being written
	input  wire logic [15:0] compareValue, // 16-bit compare value
	input  wire logic [15:0] timerCount,   // selected time base count
	output logic             pinLevel,     // compare output latch
	output logic             matchPulse,   // one-cycle match event
	output logic             triggerPulse  // one-cycle special event trigger
);

	ccp_compare_pkg::chan_s stQ;
	ccp_compare_pkg::chan_s stD;
	logic                   isCompare;
	logic                   equalNow;

	// compare modes are the five codes that carry a match action
	always_comb begin
		case (mode)
			ccp_compare_pkg::MODE_TOGGLE,
			ccp_compare_pkg::MODE_SET_HIGH,
			ccp_compare_pkg::MODE_SET_LOW,
			ccp_compare_pkg::MODE_SOFT,
			ccp_compare_pkg::MODE_TRIGGER: isCompare = 1'b1;
			default:                       isCompare = 1'b0;
		endcase
	end

	// continuous 16-bit comparison, one event on the rising edge of equality
	assign equalNow     = (compareValue == timerCount);
	assign matchPulse   = isCompare && equalNow && !stQ.equalPrev;
	assign triggerPulse = matchPulse && (mode == ccp_compare_pkg::MODE_TRIGGER);

	// next state: pin action on match, initial level on mode write
	always_comb begin
		stD           = stQ;
		stD.equalPrev = equalNow;
		if (modeWrite) begin
			case (modeNew)
				ccp_compare_pkg::MODE_OFF:      stD.pinLevel = 1'b0;
				ccp_compare_pkg::MODE_SET_HIGH: stD.pinLevel = 1'b0;
				ccp_compare_pkg::MODE_SET_LOW:  stD.pinLevel = 1'b1;
				default:                        stD.pinLevel = stQ.pinLevel;
			endcase
		end else if (matchPulse) begin
			case (mode)
				ccp_compare_pkg::MODE_TOGGLE:   stD.pinLevel = !stQ.pinLevel;
				ccp_compare_pkg::MODE_SET_HIGH: stD.pinLevel = 1'b1;
				ccp_compare_pkg::MODE_SET_LOW:  stD.pinLevel = 1'b0;
				default:                        stD.pinLevel = stQ.pinLevel;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stQ.pinLevel  <= 1'b0;
			stQ.equalPrev <= 1'b0;
		end else begin
			stQ <= stD;
		end
	end

	assign pinLevel = stQ.pinLevel;

endmodule : ccp_compare_channel

// ===== src/ccp_compare_unit.sv
// compare pair: register file, time base routing, two compare channels and triggers
//
// Function
// - each unit compares its 16-bit compare value continuously against timer A or timer B.
// - on a match the unit pin goes high, goes low, toggles or stays as the mode field selects.
// - the match flag is set on the same clock edge that performs the pin action.
// - writing zero to a control register forces that unit's compare output latch low.
// - software-interrupt mode leaves the pin alone and only raises the enabled interrupt.
// - special-event mode produces an internal trigger pulse on a match.
// - unit 1's trigger resets its selected timer so its value acts as a 16-bit period for that timer.
// - each unit's trigger resets whichever timer is its selected time base.
// - unit 2's trigger also starts a conversion, but only while the converter is enabled.
// - a timer reset from unit 2's trigger must not set the timer interrupt flags.
// - mode 0010 toggles the pin on each match and sets the match flag.
// - modes 1000/1001 start the pin low/high and drive it high/low on match, 1010 interrupts, 1011 triggers.
// - the time base of each unit comes from the time base selection bits.
`timescale 1ns/1ps
`include "ccp_compare_cfg.svh"
module ccp_compare_unit (
	input  wire logic                   clk,              // system clock, 20 MHz
	input  wire logic                   resetn,           // synchronous reset, active low
	input  wire logic [`CCP_ADDR_W-1:0] regAddr,          // register address
	input  wire logic [`CCP_DATA_W-1:0] regWrData,        // register write data
	input  wire logic                   regWrite,         // write strobe
	input  wire logic                   regRead,          // read strobe
	output logic      [`CCP_DATA_W-1:0] regRdData,        // read data, cycle after strobe
	input  wire logic [15:0]            timerACount,      // timer A count, same clock
	input  wire logic [15:0]            timerBCount,      // timer B count, same clock
	input  wire logic                   adcEnabled,       // converter module enabled
	output logic                        unit1Pin,         // unit 1 compare output level
	output logic                        unit2Pin,         // unit 2 compare output level
	output logic                        unit1MatchFlag,   // unit 1 sticky match flag
	output logic                        unit2MatchFlag,   // unit 2 sticky match flag
	output logic                        timerAReset,      // clear timer A pair, pulse
	output logic                        timerBReset,      // clear timer B pair, pulse
	output logic                        timerFlagInhibit, // suppress timer flags on this reset
	output logic                        adcStart,         // start conversion, pulse
	output logic                        irq               // level interrupt
);

	ccp_compare_pkg::regs_s rQ;
	ccp_compare_pkg::regs_s rD;

	logic [1:0]        ctrlWrite;   // control register of a unit written
	logic [1:0]        useTimerB;   // unit runs on timer B
	logic [1:0]        pinLevel;    // channel output latches
	logic [1:0]        matchPulse;  // channel match events
	logic [1:0]        trigPulse;   // channel special event triggers
	logic [1:0][15:0]  unitValue;   // assembled compare values
	logic [1:0][15:0]  unitCount;   // routed time base counts

	// address decode of one unit's byte registers
	function automatic logic isUnitReg(
		input logic [`CCP_ADDR_W-1:0] addr,
		input logic [`CCP_ADDR_W-1:0] ofsUnit1,
		input logic [`CCP_ADDR_W-1:0] ofsUnit2,
		input int                     unit
	);
		logic hit;
		hit = 1'b0;
		if (unit == 0) begin
			hit = (addr == ofsUnit1);
		end else begin
			hit = (addr == ofsUnit2);
		end
		return hit;
	endfunction : isUnitReg

	// time base selection: all on A, unit 1 on A and unit 2 on B, or all on B
	function automatic logic selectsTimerB(
		input logic [1:0] sel,
		input int         unit
	);
		logic useB;
		useB = 1'b0;
		if (sel == `TBSEL_ALL_A) begin
			useB = 1'b0;
		end else if (sel == `TBSEL_SPLIT) begin
			useB = (unit == 1);
		end else begin
			useB = 1'b1;
		end
		return useB;
	endfunction : selectsTimerB

	// per-unit datapath and channel instance
	generate
		for (genvar u = 0; u < 2; u++) begin : g_unit
			assign ctrlWrite[u] = regWrite &&
				isUnitReg(regAddr, `OFS_U1_CONTROL, `OFS_U2_CONTROL, u);
			assign useTimerB[u] = selectsTimerB(rQ.timebaseSel, u);
			assign unitValue[u] = {rQ.valueHigh[u], rQ.valueLow[u]};
			assign unitCount[u] = useTimerB[u] ? timerBCount : timerACount;

			ccp_compare_channel u_chan (
				.clk          (clk),
				.resetn       (resetn),
				.mode         (rQ.control[u][`CTRL_MODE_MSB:`CTRL_MODE_LSB]),
				.modeWrite    (ctrlWrite[u]),
				.modeNew      (regWrData[`CTRL_MODE_MSB:`CTRL_MODE_LSB]),
				.compareValue (unitValue[u]),
				.timerCount   (unitCount[u]),
				.pinLevel     (pinLevel[u]),
				.matchPulse   (matchPulse[u]),
				.triggerPulse (trigPulse[u])
			);
		end
	endgenerate

	// register file next state: writes, sticky flags with set winning over clear, read data
	always_comb begin
		rD          = rQ;
		rD.readData = rQ.readData;
		for (int u = 0; u < 2; u++) begin
			if (regWrite && isUnitReg(regAddr, `OFS_U1_VALUE_LOW, `OFS_U2_VALUE_LOW, u)) begin
				rD.valueLow[u] = regWrData;
			end
			if (regWrite && isUnitReg(regAddr, `OFS_U1_VALUE_HIGH, `OFS_U2_VALUE_HIGH, u)) begin
				rD.valueHigh[u] = regWrData;
			end
			if (ctrlWrite[u]) begin
				rD.control[u] = regWrData & `CTRL_WRITE_MASK; // bits 7:6 stay zero
			end
		end
		if (regWrite && (regAddr == `OFS_TIMEBASE_SEL)) begin
			rD.timebaseSel = regWrData[`TBSEL_MSB:`TBSEL_LSB];
		end
		if (regWrite && (regAddr == `OFS_MATCH_MASK)) begin
			rD.matchMask = regWrData[`BIT_UNIT2:`BIT_UNIT1];
		end
		// write one to clear, then a match in the same cycle sets again
		if (regWrite && (regAddr == `OFS_MATCH_STATUS)) begin
			rD.matchStatus = rQ.matchStatus & ~regWrData[`BIT_UNIT2:`BIT_UNIT1];
		end
		rD.matchStatus = rD.matchStatus | matchPulse;
		// read data is captured on the strobe and shown in the next cycle only
		if (regRead) begin
			if (regAddr == `OFS_U1_VALUE_LOW) begin
				rD.readData = rQ.valueLow[`BIT_UNIT1];
			end else if (regAddr == `OFS_U1_VALUE_HIGH) begin
				rD.readData = rQ.valueHigh[`BIT_UNIT1];
			end else if (regAddr == `OFS_U1_CONTROL) begin
				rD.readData = rQ.control[`BIT_UNIT1];
			end else if (regAddr == `OFS_U2_VALUE_LOW) begin
				rD.readData = rQ.valueLow[`BIT_UNIT2];
			end else if (regAddr == `OFS_U2_VALUE_HIGH) begin
				rD.readData = rQ.valueHigh[`BIT_UNIT2];
			end else if (regAddr == `OFS_U2_CONTROL) begin
				rD.readData = rQ.control[`BIT_UNIT2];
			end else if (regAddr == `OFS_TIMEBASE_SEL) begin
				rD.readData = {6'h00, rQ.timebaseSel};
			end else if (regAddr == `OFS_MATCH_STATUS) begin
				rD.readData = {6'h00, rQ.matchStatus};
			end else if (regAddr == `OFS_MATCH_MASK) begin
				rD.readData = {6'h00, rQ.matchMask};
			end else if (regAddr == `OFS_PIN_STATE) begin
				rD.readData = {6'h00, pinLevel};
			end else begin
				rD.readData = `READ_ZERO;
			end
		end else begin
			rD.readData = `READ_ZERO;
		end
	end

	// register file state
	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int u = 0; u < 2; u++) begin
				rQ.valueLow[u]  <= `BYTE_RESET;
				rQ.valueHigh[u] <= `BYTE_RESET;
				rQ.control[u]   <= `CTRL_RESET;
			end
			rQ.timebaseSel <= `TBSEL_RESET;
			rQ.matchStatus <= `FLAGS_RESET;
			rQ.matchMask   <= `FLAGS_RESET;
			rQ.readData    <= `READ_ZERO;
		end else begin
			rQ <= rD;
		end
	end

	// triggers reset the selected time base of the unit that fired
	assign timerAReset = (trigPulse[`BIT_UNIT1] && !useTimerB[`BIT_UNIT1]) ||
	                     (trigPulse[`BIT_UNIT2] && !useTimerB[`BIT_UNIT2]);
	assign timerBReset = (trigPulse[`BIT_UNIT1] && useTimerB[`BIT_UNIT1]) ||
	                     (trigPulse[`BIT_UNIT2] && useTimerB[`BIT_UNIT2]);
	assign timerFlagInhibit = trigPulse[`BIT_UNIT2];
	assign adcStart         = trigPulse[`BIT_UNIT2] && adcEnabled;

	// outputs: pins and flags straight from flops, interrupt gated by the mask
	assign unit1Pin       = pinLevel[`BIT_UNIT1];
	assign unit2Pin       = pinLevel[`BIT_UNIT2];
	assign unit1MatchFlag = rQ.matchStatus[`BIT_UNIT1];
	assign unit2MatchFlag = rQ.matchStatus[`BIT_UNIT2];
	assign irq            = |(rQ.matchStatus & rQ.matchMask);
	assign regRdData      = rQ.readData;

endmodule : ccp_compare_unit

// ===== test/ccp_compare_unit_assertions.sv
// port assertions of the compare pair
`timescale 1ns/1ps
module ccp_compare_unit_checker (
	input wire logic       clk,              // clock
	input wire logic       resetn,           // reset, active low
	input wire logic       regWrite,         // write strobe
	input wire logic       regRead,          // read strobe
	input wire logic [7:0] regRdData,        // read data
	input wire logic       adcEnabled,       // converter on
	input wire logic       unit1Pin,         // unit 1 pin
	input wire logic       unit2Pin,         // unit 2 pin
	input wire logic       unit1MatchFlag,   // unit 1 flag
	input wire logic       unit2MatchFlag,   // unit 2 flag
	input wire logic       timerAReset,      // timer A clear
	input wire logic       timerBReset,      // timer B clear
	input wire logic       timerFlagInhibit, // timer flag block
	input wire logic       adcStart,         // conversion start
	input wire logic       irq               // interrupt
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// event outputs against their causes
	chk_adc_gated: assert property (adcStart |-> adcEnabled && timerFlagInhibit)
		else $error("conversion start without enabled trigger");
	chk_inhibit_resets: assert property (timerFlagInhibit |-> timerAReset || timerBReset)
		else $error("flag inhibit without timer clear");
	chk_inhibit_flag: assert property (timerFlagInhibit |=> unit2MatchFlag)
		else $error("unit 2 trigger without flag");
	chk_trig_flag: assert property (timerAReset || timerBReset |=> unit1MatchFlag || unit2MatchFlag)
		else $error("timer clear without match flag");
	// pin moves only by a mode write or a flagged match
	chk_pin1_flag: assert property ($changed(unit1Pin) && !$past(regWrite) |-> unit1MatchFlag)
		else $error("unit 1 pin moved without flag");
	chk_pin2_flag: assert property ($changed(unit2Pin) && !$past(regWrite) |-> unit2MatchFlag)
		else $error("unit 2 pin moved without flag");
	chk_flag_sticky: assert property (unit1MatchFlag && !regWrite |=> unit1MatchFlag)
		else $error("unit 1 flag dropped without write");
	chk_irq_cause: assert property (irq |-> unit1MatchFlag || unit2MatchFlag)
		else $error("interrupt without flag");
	chk_read_idle: assert property (!$past(regRead) |-> regRdData == 8'h00)
		else $error("read data outside answer cycle");

	cov_adc: cover property (adcStart);
	cov_timer_b: cover property (timerBReset);
	cov_irq: cover property ($rose(irq));
endmodule : ccp_compare_unit_checker

bind ccp_compare_unit ccp_compare_unit_checker chk_u (
	.clk(clk), .resetn(resetn), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
	.adcEnabled(adcEnabled), .unit1Pin(unit1Pin), .unit2Pin(unit2Pin), .unit1MatchFlag(unit1MatchFlag),
	.unit2MatchFlag(unit2MatchFlag), .timerAReset(timerAReset), .timerBReset(timerBReset),
	.timerFlagInhibit(timerFlagInhibit), .adcStart(adcStart), .irq(irq)
);

// ===== test/ccp_timer_partner.sv
// timer pair and conversion counter facing the compare pair
`timescale 1ns/1ps
module ccp_timer_partner (
	input  wire logic        clk,    // system clock
	input  wire logic        resetn, // reset, active low
	input  wire logic        run,    // advance both timers
	input  wire logic        ldA,    // load timer A
	input  wire logic        ldB,    // load timer B
	input  wire logic [15:0] ldVal,  // load value
	input  wire logic        rstA,   // clear timer A
	input  wire logic        rstB,   // clear timer B
	input  wire logic        adcGo,  // conversion start
	output logic      [15:0] cntA,   // timer A count
	output logic      [15:0] cntB,   // timer B count
	output int               adcCnt  // conversions started
);
	// timers step on the system clock only, so compare sees synchronous counts
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cntA <= 16'h0000;
			cntB <= 16'h0000;
			adcCnt <= 0;
		end else begin
			cntA <= rstA ? 16'h0000 : ldA ? ldVal : cntA + 16'(run);
			cntB <= rstB ? 16'h0000 : ldB ? ldVal : cntB + 16'(run);
			adcCnt <= adcCnt + int'(adcGo);
		end
	end
endmodule : ccp_timer_partner

// ===== test/ccp_compare_unit_tb_top.sv
// testbench of the compare pair with a timer partner and a rule model
`timescale 1ns/1ps
`include "ccp_compare_cfg.svh"
module ccp_compare_unit_tb_top;
	logic        clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic        adcEnabled = 1'b0, run = 1'b0, ldA = 1'b0, ldB = 1'b0;
	logic [3:0]  regAddr = 4'h0;
	logic [7:0]  regWrData = 8'h00;
	logic [15:0] ldVal = 16'h0000;
	logic [7:0]  regRdData;
	logic [15:0] cntA, cntB;
	logic [1:0]  pin, flg;       // pins read as driven outputs, direction bits taken as cleared
	logic        rstA, rstB, adcGo, irq, inh;
	logic [1:0]  tbSel = 2'h1;   // time base select as programmed
	int          adcCnt;
	int          inhCnt = 0;
	int          failCount = 0;
	int          numChecks = 0;
	logic [3:0]  modes[$] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB, 4'hB, 4'hC};

	// 20 MHz clock
	always #25 clk = ~clk;

	ccp_compare_unit dut_u (
		.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .timerACount(cntA), .timerBCount(cntB),
		.adcEnabled(adcEnabled), .unit1Pin(pin[0]), .unit2Pin(pin[1]), .unit1MatchFlag(flg[0]),
		.unit2MatchFlag(flg[1]), .timerAReset(rstA), .timerBReset(rstB), .timerFlagInhibit(inh),
		.adcStart(adcGo), .irq(irq)
	);
	ccp_timer_partner tmr_u (
		.clk(clk), .resetn(resetn), .run(run), .ldA(ldA), .ldB(ldB), .ldVal(ldVal),
		.rstA(rstA), .rstB(rstB), .adcGo(adcGo), .cntA(cntA), .cntB(cntB), .adcCnt(adcCnt)
	);

	// count flag inhibits that the timer pair sees
	always @(posedge clk)
		if (inh === 1'b1) inhCnt <= inhCnt + 1;

	task automatic summarize();
		if (failCount == 0 && numChecks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		numChecks++;
		if (g !== e) begin
			failCount++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask : chk

	// one-cycle strobes, an idle cycle after each
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(posedge clk);
		chk(regRdData, e);
	endtask : rd

	// program a unit, run its timer onto the value, then hold equality
	task automatic run_case(input int u, input logic [3:0] m, input logic ae);
		logic [15:0] v;
		logic [3:0]  c;
		logic        mk, ep, onB;
		int          a0, i0;
		v = 16'($urandom_range(16'hFF00, 16'h0100));
		mk = 1'($urandom);
		c = 4'(u * 3);
		ep = (m == 4'h8) || (m == 4'h2);
		onB = (tbSel == 2'h1) ? (u == 1) : tbSel[1];
		wr(`OFS_MATCH_STATUS, 8'h03);
		wr(c + 4'h2, 8'h00);
		chk(pin[u], 1'b0);
		wr(c, v[7:0]);
		wr(c + 4'h1, v[15:8]);
		wr(`OFS_MATCH_MASK, 8'(mk) << u);
		adcEnabled <= ae;
		wr(c + 4'h2, {4'hC, m});
		rd(c + 4'h2, {4'h0, m});
		rd(c + 4'h1, v[15:8]);
		chk(pin[u], m == 4'h9);
		ldVal <= v - 16'h0002;
		ldA <= !onB;
		ldB <= onB;
		@(posedge clk);
		ldA <= 1'b0;
		ldB <= 1'b0;
		run <= 1'b1;
		a0 = adcCnt;
		i0 = inhCnt;
		repeat (2) @(posedge clk);
		run <= 1'b0;
		repeat (4) @(posedge clk);
		chk(pin[u], ep);
		chk(flg[u], m != 4'hC);
		chk(irq, mk && m != 4'hC);
		chk(onB ? cntB : cntA, m == 4'hB ? 16'h0000 : v);
		chk(16'(adcCnt - a0), u == 1 && m == 4'hB && ae);
		chk(16'(inhCnt - i0), u == 1 && m == 4'hB);
		wr(`OFS_MATCH_STATUS, 8'h03);
		repeat (3) @(posedge clk);
		rd(`OFS_MATCH_STATUS, 8'h00);
		rd(`OFS_PIN_STATE, 8'(ep) << u);
	endtask : run_case

	// main sequence
	initial begin
		void'($urandom(30));
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (int a = 0; a < 16; a++)
			rd(4'(a), 8'h00);
		wr(4'hA, 8'hFF);
		rd(4'hA, 8'h00);
		wr(`OFS_TIMEBASE_SEL, 8'h01);
		rd(`OFS_TIMEBASE_SEL, 8'h01);
		for (int u = 0; u < 2; u++)
			foreach (modes[i]) run_case(u, modes[i], 1'(i));
		// the other time base codes: both units on timer B, then both on timer A
		wr(`OFS_TIMEBASE_SEL, 8'h02);
		tbSel = 2'h2;
		run_case(0, 4'hB, 1'b1);
		wr(`OFS_U1_CONTROL, 8'h00);
		wr(`OFS_TIMEBASE_SEL, 8'h00);
		tbSel = 2'h0;
		run_case(1, 4'hB, 1'b1);
		summarize();
	end

	// watchdog
	initial begin
		repeat (5000) @(posedge clk);
		failCount++;
		$display("CHECK FAILED %0t timeout", $time);
		summarize();
	end
endmodule : ccp_compare_unit_tb_top
